// ===== verilog/deframer_ctrl_pkg.sv
package deframer_ctrl_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int LANES  = 8;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_LANE_SYNC = 12'h473;
  localparam logic [ADDR_W-1:0] ADDR_CTRL_A    = 12'h475;
  localparam logic [ADDR_W-1:0] ADDR_CTRL_B    = 12'h476;

  // ----------------------------------------------------------------
  // Field positions, control A
  // ----------------------------------------------------------------
  localparam int A_RX_DISABLE  = 7;
  localparam int A_REPL_DIS    = 6;
  localparam int A_SOFT_RESET  = 3;
  localparam int A_FORCE_SYNC  = 2;
  localparam int A_FRAME_REPL  = 0;

  // ----------------------------------------------------------------
  // Field positions, control B
  // ----------------------------------------------------------------
  localparam int B_ERR_QUALIFY = 4;
  localparam int B_DESCRAMBLE  = 3;
  localparam int B_POST_SYNC   = 2;
  localparam int B_OMIT_ALIGN  = 1;

  // ----------------------------------------------------------------
  // Reset values and writable masks (reserved bits read zero)
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] CTRL_A_RESET = 8'h01;
  localparam logic [DATA_W-1:0] CTRL_B_RESET = 8'h14;
  localparam logic [DATA_W-1:0] CTRL_A_MASK  = 8'hCD;
  localparam logic [DATA_W-1:0] CTRL_B_MASK  = 8'h1E;
  localparam logic [DATA_W-1:0] ZERO_BYTE    = 8'h00;
  localparam logic [LANES-1:0]  LANES_LOST   = 8'h00;

  // ----------------------------------------------------------------
  // Control characters
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] CHAR_K = 8'hBC;
  localparam logic [DATA_W-1:0] CHAR_R = 8'h1C;
  localparam logic [DATA_W-1:0] CHAR_A = 8'h7C;
  localparam logic [DATA_W-1:0] CHAR_F = 8'hFC;

  // ----------------------------------------------------------------
  // Post code group sync checker states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CG_WAIT   = 2'b00,
    CG_SYNCED = 2'b01,
    CG_SEEN_K = 2'b10
  } cg_state_e;

  function automatic logic is_ctrl(input logic [DATA_W-1:0] ch,
                                   input logic              k,
                                   input logic [DATA_W-1:0] code);
    is_ctrl = k && (ch == code);
  endfunction : is_ctrl

endpackage : deframer_ctrl_pkg

// ===== verilog/char_replace.sv
`timescale 1ns/100ps

module char_replace (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       flush_i,
  input  wire logic [7:0] char_i,
  input  wire logic       is_k_i,
  input  wire logic       valid_i,
  input  wire logic       end_frame_i,
  input  wire logic       end_multiframe_i,
  input  wire logic       frame_err_i,
  input  wire logic       repl_disable_i,
  input  wire logic       frame_repl_i,
  output logic      [7:0] char_o,
  output logic            is_k_o,
  output logic            valid_o
);

  logic [7:0] last_char;
  logic       align_hit;
  logic       err_hit;

  // ----------------------------------------------------------------
  // Substitution decode
  // ----------------------------------------------------------------
  always_comb begin
    align_hit = !repl_disable_i &&
      ((end_frame_i &&
        deframer_ctrl_pkg::is_ctrl(char_i, is_k_i,
                                   deframer_ctrl_pkg::CHAR_F)) ||
       (end_multiframe_i &&
        deframer_ctrl_pkg::is_ctrl(char_i, is_k_i,
                                   deframer_ctrl_pkg::CHAR_A)));
    err_hit = frame_repl_i && frame_err_i;
  end

  // ----------------------------------------------------------------
  // Output stage; the previous good octet stands in for a replaced one
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i || flush_i) begin
      char_o    <= deframer_ctrl_pkg::ZERO_BYTE;
      is_k_o    <= 1'b0;
      valid_o   <= 1'b0;
      last_char <= deframer_ctrl_pkg::ZERO_BYTE;
    end else begin
      valid_o <= valid_i;
      if (valid_i && (align_hit || err_hit)) begin
        char_o <= last_char;
        is_k_o <= 1'b0;
      end else begin
        char_o <= char_i;
        is_k_o <= is_k_i;
        if (valid_i && !is_k_i) begin
          last_char <= char_i;
        end
      end
    end
  end

endmodule : char_replace

// ===== verilog/serial_link_deframer_ctrl_status.sv
`timescale 1ns/100ps

// Summary of operation
// - Per-lane alignment sync status, bit n lane n
// - Receiver disable bit stops deframer reception
// - Replacement disable bit stops end character substitution
// - Otherwise substitute /A/ and /F/ at ends
// - Soft reset bit holds deframer, zero runs
// - Force bit asserts sync request toward transmitter
// - Errored frames replaced when enable set, default on
// - Qualify bit lets not-in-table mask disparity error
// - Post-sync select bit chooses behaviour, default one
// - Select one: /K/ then non /R/ /K/ requests sync
// - Omit alignment: user data directly after sync
module serial_link_deframer_ctrl_status (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Register port
  input  wire logic [11:0] reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [7:0]  reg_rdata_o,
  // Lane status from the lane front ends
  input  wire logic [7:0]  lane_alignment_sync_i,
  input  wire logic        code_group_sync_i,
  // Received character stream
  input  wire logic [7:0]  rx_char_i,
  input  wire logic        rx_is_k_i,
  input  wire logic        rx_valid_i,
  input  wire logic        end_frame_i,
  input  wire logic        end_multiframe_i,
  input  wire logic        frame_err_i,
  input  wire logic        not_in_table_error_i,
  input  wire logic        disparity_error_i,
  // Outputs
  output logic      [7:0]  user_char_o,
  output logic             user_is_k_o,
  output logic             user_valid_o,
  output logic             disparity_error_o,
  output logic             sync_request_out_o,
  output logic             deframer_reset_o,
  output logic             descrambler_option_o
);

  logic [7:0]                      deframer_control_a;
  logic [7:0]                      deframer_control_b;
  logic [7:0]                      lane_alignment_sync_status;
  deframer_ctrl_pkg::cg_state_e    cg_state;
  deframer_ctrl_pkg::cg_state_e    next_cg_state;
  logic                            soft_reset;
  logic                            rx_active;
  logic                            k_violation;
  logic                            data_phase;
  logic                            stream_valid;
  logic                            char_valid;

  // ----------------------------------------------------------------
  // Control field decode
  // ----------------------------------------------------------------
  always_comb begin
    soft_reset = deframer_control_a[deframer_ctrl_pkg::A_SOFT_RESET];
    rx_active  = !soft_reset &&
                 !deframer_control_a[deframer_ctrl_pkg::A_RX_DISABLE];
    char_valid = rx_valid_i && rx_active;
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Configuration bits are meant to move only under soft reset; the
  // hardware does not police that, so a live change is taken as is.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      deframer_control_a <= deframer_ctrl_pkg::CTRL_A_RESET;
    end else if (reg_wr_i &&
                 reg_addr_i == deframer_ctrl_pkg::ADDR_CTRL_A) begin
      deframer_control_a <= reg_wdata_i & deframer_ctrl_pkg::CTRL_A_MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      deframer_control_b <= deframer_ctrl_pkg::CTRL_B_RESET;
    end else if (reg_wr_i &&
                 reg_addr_i == deframer_ctrl_pkg::ADDR_CTRL_B) begin
      deframer_control_b <= reg_wdata_i & deframer_ctrl_pkg::CTRL_B_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Lane alignment sync status
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i || soft_reset) begin
      lane_alignment_sync_status <= deframer_ctrl_pkg::LANES_LOST;
    end else begin
      lane_alignment_sync_status <= lane_alignment_sync_i;
    end
  end

  // ----------------------------------------------------------------
  // Register reads, one cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= deframer_ctrl_pkg::ZERO_BYTE;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        deframer_ctrl_pkg::ADDR_LANE_SYNC: begin
          reg_rdata_o <= lane_alignment_sync_status;
        end
        deframer_ctrl_pkg::ADDR_CTRL_A: begin
          reg_rdata_o <= deframer_control_a;
        end
        deframer_ctrl_pkg::ADDR_CTRL_B: begin
          reg_rdata_o <= deframer_control_b;
        end
        default: begin
          reg_rdata_o <= deframer_ctrl_pkg::ZERO_BYTE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Post code group sync checker
  // ----------------------------------------------------------------
  always_comb begin
    next_cg_state = cg_state;
    k_violation   = 1'b0;
    case (cg_state)
      deframer_ctrl_pkg::CG_WAIT: begin
        if (code_group_sync_i) begin
          next_cg_state = deframer_ctrl_pkg::CG_SYNCED;
        end
      end
      deframer_ctrl_pkg::CG_SYNCED: begin
        if (char_valid && deframer_ctrl_pkg::is_ctrl(rx_char_i, rx_is_k_i,
                                          deframer_ctrl_pkg::CHAR_K)) begin
          next_cg_state = deframer_ctrl_pkg::CG_SEEN_K;
        end
      end
      deframer_ctrl_pkg::CG_SEEN_K: begin
        if (char_valid && !deframer_ctrl_pkg::is_ctrl(rx_char_i, rx_is_k_i,
                                          deframer_ctrl_pkg::CHAR_K)) begin
          next_cg_state = deframer_ctrl_pkg::CG_SYNCED;
          k_violation   = !deframer_ctrl_pkg::is_ctrl(rx_char_i, rx_is_k_i,
                                          deframer_ctrl_pkg::CHAR_R);
        end
      end
      default: begin
        next_cg_state = deframer_ctrl_pkg::CG_WAIT;
      end
    endcase
    if (!code_group_sync_i) begin
      next_cg_state = deframer_ctrl_pkg::CG_WAIT;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !rx_active) begin
      cg_state <= deframer_ctrl_pkg::CG_WAIT;
    end else begin
      cg_state <= next_cg_state;
    end
  end

  // ----------------------------------------------------------------
  // Sync request toward the transmitter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_request_out_o <= 1'b0;
    end else begin
      sync_request_out_o <=
        deframer_control_a[deframer_ctrl_pkg::A_FORCE_SYNC] ||
        (k_violation &&
         deframer_control_b[deframer_ctrl_pkg::B_POST_SYNC]);
    end
  end

  // ----------------------------------------------------------------
  // Error qualification
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i || !rx_active) begin
      disparity_error_o <= 1'b0;
    end else begin
      disparity_error_o <= rx_valid_i && disparity_error_i &&
        !(deframer_control_b[deframer_ctrl_pkg::B_ERR_QUALIFY] &&
          not_in_table_error_i);
    end
  end

  // ----------------------------------------------------------------
  // User data gating
  // ----------------------------------------------------------------
  // Alignment omission is only legal on a single lane; with several
  // lanes the full alignment must be seen before data counts. The logic
  // does not check the lane count: the omit bit alone passes data on code group sync.
  always_comb begin
    data_phase = code_group_sync_i &&
      (deframer_control_b[deframer_ctrl_pkg::B_OMIT_ALIGN] ||
       (&lane_alignment_sync_status));
    stream_valid = char_valid && data_phase;
  end

  char_replace u_char_replace (
    .clk_i            (clk_i),
    .rst_i            (rst_i),
    .flush_i          (!rx_active),
    .char_i           (rx_char_i),
    .is_k_i           (rx_is_k_i),
    .valid_i          (stream_valid),
    .end_frame_i      (end_frame_i),
    .end_multiframe_i (end_multiframe_i),
    .frame_err_i      (frame_err_i),
    .repl_disable_i   (deframer_control_a[deframer_ctrl_pkg::A_REPL_DIS]),
    .frame_repl_i     (deframer_control_a[deframer_ctrl_pkg::A_FRAME_REPL]),
    .char_o           (user_char_o),
    .is_k_o           (user_is_k_o),
    .valid_o          (user_valid_o)
  );

  // ----------------------------------------------------------------
  // Configuration outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      deframer_reset_o     <= 1'b0;
      descrambler_option_o <= 1'b0;
    end else begin
      deframer_reset_o     <= soft_reset;
      descrambler_option_o <=
        deframer_control_b[deframer_ctrl_pkg::B_DESCRAMBLE];
    end
  end

endmodule : serial_link_deframer_ctrl_status

// ===== testbench/deframer_chk.sv
`timescale 1ns/100ps

module deframer_chk (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [11:0] reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_rdata_o,
  input  wire logic [7:0]  lane_alignment_sync_i,
  input  wire logic [7:0]  rx_char_i,
  input  wire logic        rx_is_k_i,
  input  wire logic        rx_valid_i,
  input  wire logic        frame_err_i,
  input  wire logic        not_in_table_error_i,
  input  wire logic        disparity_error_i,
  input  wire logic [7:0]  user_char_o,
  input  wire logic        user_valid_o,
  input  wire logic        disparity_error_o,
  input  wire logic        sync_request_out_o,
  input  wire logic        deframer_reset_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic rd_sync;
  logic wr_ctrl;
  logic rst_bit;
  assign rd_sync = reg_rd_i && reg_addr_i == deframer_ctrl_pkg::ADDR_LANE_SYNC;
  assign wr_ctrl = reg_wr_i && reg_addr_i == deframer_ctrl_pkg::ADDR_CTRL_A;
  assign rst_bit = reg_wdata_i[deframer_ctrl_pkg::A_SOFT_RESET];

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  sequence k_seen;
    rx_valid_i && rx_is_k_i && rx_char_i == deframer_ctrl_pkg::CHAR_K;
  endsequence
  sequence bad_next;
    rx_valid_i && !rx_is_k_i && user_valid_o
      && rx_char_i != deframer_ctrl_pkg::CHAR_R;
  endsequence

  // Two quiet cycles keep the soft reset edge out of the window
  status_rd_a: assert property (
    rd_sync && !deframer_reset_o && !$past(deframer_reset_o)
      && !$past(rst_i) |=> reg_rdata_o == $past(lane_alignment_sync_i, 2))
    else $error("status read differs from lane inputs");
  soft_rst_lost_a: assert property (
    rd_sync && deframer_reset_o && $past(deframer_reset_o)
      |=> reg_rdata_o == deframer_ctrl_pkg::LANES_LOST)
    else $error("status not lost during soft reset");
  force_sync_a: assert property (
    wr_ctrl && reg_wdata_i[deframer_ctrl_pkg::A_FORCE_SYNC]
      |-> ##2 sync_request_out_o)
    else $error("forced sync request missing");
  soft_rst_pin_a: assert property (
    wr_ctrl |-> ##2 deframer_reset_o == $past(rst_bit, 2))
    else $error("soft reset output wrong");
  rx_off_a: assert property (
    deframer_reset_o && $past(deframer_reset_o) |-> !user_valid_o)
    else $error("output during soft reset");
  disp_pass_a: assert property (
    rx_valid_i && disparity_error_i && !not_in_table_error_i
      |=> disparity_error_o || !user_valid_o)
    else $error("disparity error lost");
  disp_quiet_a: assert property (
    !(rx_valid_i && disparity_error_i) |=> !disparity_error_o)
    else $error("spurious disparity error");
  stream_pass_a: assert property (
    rx_valid_i && !rx_is_k_i && !frame_err_i
      |=> !user_valid_o || user_char_o == $past(rx_char_i))
    else $error("good data character altered");
  k_resync_a: assert property (
    k_seen ##1 bad_next |=> sync_request_out_o)
    else $error("no sync request after bad K sequence");
endmodule : deframer_chk

bind serial_link_deframer_ctrl_status deframer_chk deframer_chk_inst (
  .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .lane_alignment_sync_i(lane_alignment_sync_i),
  .rx_char_i(rx_char_i), .rx_is_k_i(rx_is_k_i), .rx_valid_i(rx_valid_i),
  .frame_err_i(frame_err_i), .not_in_table_error_i(not_in_table_error_i),
  .disparity_error_i(disparity_error_i), .user_char_o(user_char_o),
  .user_valid_o(user_valid_o), .disparity_error_o(disparity_error_o),
  .sync_request_out_o(sync_request_out_o),
  .deframer_reset_o(deframer_reset_o));

// ===== testbench/framer_model.sv
`timescale 1ns/100ps

module framer_model (
  input  wire logic       clk_i,
  output logic      [7:0] char_o,
  output logic      [5:0] flags_o,
  output logic            valid_o
);
  // Flags are {k, end frame, end multiframe, frame err, nit, disparity}
  initial begin
    char_o  = 8'h00;
    flags_o = 6'h00;
    valid_o = 1'b0;
  end

  task automatic send(input logic [7:0] ch, input logic [5:0] fl);
    @(posedge clk_i);
    char_o  <= ch;
    flags_o <= fl;
    valid_o <= 1'b1;
  endtask : send

  // Released lines flip so a stale value never looks valid
  task automatic idle();
    @(posedge clk_i);
    char_o  <= ~char_o;
    flags_o <= ~flags_o;
    valid_o <= 1'b0;
  endtask : idle
endmodule : framer_model

// ===== testbench/tb_top.sv
`timescale 1ns/100ps

module tb_top;
  localparam logic [11:0] RA = deframer_ctrl_pkg::ADDR_CTRL_A;
  localparam logic [11:0] RB = deframer_ctrl_pkg::ADDR_CTRL_B;
  localparam logic [11:0] RS = deframer_ctrl_pkg::ADDR_LANE_SYNC;
  localparam logic [7:0]  CF = deframer_ctrl_pkg::CHAR_F;
  localparam logic [7:0]  CA = deframer_ctrl_pkg::CHAR_A;
  typedef struct packed {
    logic [7:0] ch;
    logic [5:0] fl;
    logic [7:0] exp;
    logic       exp_k;
    logic       exp_d;
  } row_s;
  row_s rows [8] = '{'{8'h11, 6'h00, 8'h11, 1'b0, 1'b0},
    '{CF, 6'h30, 8'h11, 1'b0, 1'b0}, '{8'h22, 6'h00, 8'h22, 1'b0, 1'b0},
    '{CA, 6'h28, 8'h22, 1'b0, 1'b0}, '{8'h33, 6'h04, 8'h22, 1'b0, 1'b0},
    '{8'h44, 6'h01, 8'h44, 1'b0, 1'b1}, '{8'h55, 6'h03, 8'h55, 1'b0, 1'b0},
    '{CF, 6'h20, CF, 1'b1, 1'b0}};
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [11:0] addr  = 12'h000;
  logic [7:0]  wdata = 8'h00;
  logic        wr    = 1'b0;
  logic        rd    = 1'b0;
  logic [7:0]  lanes = 8'hFF;
  logic        cgs   = 1'b1;
  logic [7:0]  rdata, mchar, uchar;
  logic [5:0]  mfl;
  logic        mvalid, uk, uvalid, disp, sync, dres, dscr;
  int          errors = 0;
  int          compares = 0;

  always #50 clk_i = ~clk_i;

  framer_model framer_model_inst (.clk_i(clk_i), .char_o(mchar),
    .flags_o(mfl), .valid_o(mvalid));
  serial_link_deframer_ctrl_status serial_link_deframer_ctrl_status_inst (
    .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .lane_alignment_sync_i(lanes), .code_group_sync_i(cgs),
    .rx_char_i(mchar), .rx_is_k_i(mfl[5]), .rx_valid_i(mvalid),
    .end_frame_i(mfl[4]), .end_multiframe_i(mfl[3]), .frame_err_i(mfl[2]),
    .not_in_table_error_i(mfl[1]), .disparity_error_i(mfl[0]),
    .user_char_o(uchar), .user_is_k_o(uk), .user_valid_o(uvalid),
    .disparity_error_o(disp), .sync_request_out_o(sync),
    .deframer_reset_o(dres), .descrambler_option_o(dscr));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic end_sim();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim

  task automatic rdc(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask : rdc

  task automatic wrd(input logic [11:0] a, input logic [7:0] d,
                     input logic [7:0] e);
    @(posedge clk_i);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
    rdc(a, e);
  endtask : wrd

  task automatic xfer(input logic [7:0] ch, input logic [5:0] fl);
    framer_model_inst.send(ch, fl);
    // Output of the character stands right after the idle edge
    framer_model_inst.idle();
    #1;
  endtask : xfer

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    repeat (3000) @(posedge clk_i);
    errors++;
    end_sim();
  end

  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(RA, deframer_ctrl_pkg::CTRL_A_RESET);
    rdc(RB, deframer_ctrl_pkg::CTRL_B_RESET);
    foreach (rows[i]) begin
      xfer(rows[i].ch, rows[i].fl);
      chk(uchar, rows[i].exp);
      chk({7'h00, uk}, {7'h00, rows[i].exp_k});
      chk({7'h00, disp}, {7'h00, rows[i].exp_d});
    end
    framer_model_inst.send(deframer_ctrl_pkg::CHAR_K, 6'h20);
    // The request is a one-cycle pulse, so look right after the bad char
    xfer(8'h66, 6'h00);
    chk({7'h00, sync}, 8'h01);
    // Control B settings change only inside soft reset
    wrd(RA, 8'hFF, 8'hCD);
    chk({7'h00, dres}, 8'h01);
    wrd(RB, 8'hFF, 8'h1E);
    chk({7'h00, dscr}, 8'h01);
    wrd(RB, 8'h04, 8'h04);
    chk({7'h00, dscr}, 8'h00);
    wrd(12'h474, 8'hFF, 8'h00);
    wrd(RS, 8'hFF, 8'h00);
    wrd(RA, 8'h40, 8'h40);
    xfer(CF, 6'h30);
    chk(uchar, CF);
    xfer(8'h77, 6'h04);
    chk(uchar, 8'h77);
    xfer(8'h55, 6'h03);
    chk({7'h00, disp}, 8'h01);
    @(posedge clk_i);
    lanes <= 8'h5A;
    rdc(RS, 8'h5A);
    xfer(8'h12, 6'h00);
    chk({7'h00, uvalid}, 8'h00);
    wrd(RA, 8'h48, 8'h48);
    wrd(RB, 8'h06, 8'h06);
    wrd(RA, 8'h40, 8'h40);
    xfer(8'h13, 6'h00);
    chk(uchar, 8'h13);
    wrd(RA, 8'hC8, 8'hC8);
    wrd(RA, 8'h80, 8'h80);
    xfer(8'h21, 6'h00);
    chk({7'h00, uvalid}, 8'h00);
    wrd(RA, 8'h04, 8'h04);
    chk({7'h00, sync}, 8'h01);
    end_sim();
  end
endmodule : tb_top
